// ---- design/otsu_axil_slave.v ----
// Purpose: AXI4-Lite slave front end, one write and one read in flight
// Assumes: register decode answers combinationally from word index
// Notes: write strobes in the first cycle that both address and data are held
`timescale 1ns/1ps
`include "otsu_consts.vh"
module otsu_axil_slave (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  output wire awready,
  input wire [11:0] awaddr,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output wire bvalid,
  input wire bready,
  output wire [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [11:0] araddr,
  output wire rvalid,
  input wire rready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire wr_en,
  output wire [7:0] wr_idx,
  output wire [31:0] wr_data,
  output wire [3:0] wr_strb,
  input wire wr_ok,
  output wire [7:0] rd_idx,
  input wire [31:0] rd_data,
  input wire rd_ok
);
  reg aw_held_q;
  reg [11:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire rd_take;
  wire wr_range;
  wire rd_range;

  assign awready = !aw_held_q && !bvalid_q;
  assign wready = !w_held_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign rd_take = arvalid && arready;
  assign wr_en = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = aw_addr_q[9:2];
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign rd_idx = araddr[9:2];
  // addresses past the index space fall outside every register
  assign wr_range = (aw_addr_q[11:10] == 2'h0);
  assign rd_range = (araddr[11:10] == 2'h0);
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `OTSU_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_en) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ok && wr_range) ? `OTSU_RESP_OKAY : `OTSU_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `OTSU_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= (rd_ok && rd_range) ? rd_data : 32'h0000_0000;
      rresp_q <= (rd_ok && rd_range) ? `OTSU_RESP_OKAY : `OTSU_RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// ---- design/otsu_consts.vh ----
// Purpose: constants of the output tie-off and serial unlock register slice
// Assumes: register index * 4 gives the AXI byte address
// Notes: definitions only
`ifndef OTSU_CONSTS_VH
`define OTSU_CONSTS_VH

// register indices
`define OTSU_IDX_MUTE_STATUS 8'h4e
`define OTSU_IDX_OVERRIDE 8'h4f
`define OTSU_IDX_UNLOCK_A 8'h57
`define OTSU_IDX_UNLOCK_B 8'h6c
`define OTSU_IDX_UNLOCK_C 8'h73
`define OTSU_IDX_IRQ_STATUS 8'h80
`define OTSU_IDX_IRQ_CLEAR 8'h81
`define OTSU_IDX_IRQ_ENABLE 8'h82
`define OTSU_IDX_SERIAL_STATUS 8'h83

// reset values
`define OTSU_RST_REG9 9'h000
`define OTSU_RST_IRQ 4'h0

// unlock values for 4-wire serial control
`define OTSU_UNLOCK_A_VAL 9'h115
`define OTSU_UNLOCK_B_VAL 9'h03b
`define OTSU_UNLOCK_C_VAL 9'h129

// override register fields
`define OTSU_OVR_ENABLE 8
`define OTSU_OVR_BUF_BOOST 7
`define OTSU_OVR_BUF_UNITY 6
`define OTSU_OVR_LSPK 5
`define OTSU_OVR_RSPK 4
`define OTSU_OVR_AUX1 3
`define OTSU_OVR_AUX2 2
`define OTSU_OVR_LHP 1
`define OTSU_OVR_RHP 0

// mute status fields
`define OTSU_MUTE_ANALOG 2
`define OTSU_MUTE_LEFT 1
`define OTSU_MUTE_RIGHT 0

// interrupt event bits
`define OTSU_EV_ANALOG 0
`define OTSU_EV_LEFT 1
`define OTSU_EV_RIGHT 2
`define OTSU_EV_UNLOCK 3

// bus responses
`define OTSU_RESP_OKAY 2'b00
`define OTSU_RESP_SLVERR 2'b10

`endif

// ---- design/otsu_regs.v ----
// Purpose: output tie-off override, mute status and serial unlock registers
// Assumes: AXI4-Lite register access, mute and switch inputs on aclk
// Notes: byte address is four times the register index
//
// Functional notes
// [RQ1] The analog automute flag reads 1 while the DAC channels are automuted, else 0.
// [RQ2] Each digital mute flag reads 1 when its channel DAC gain is zero, else 0.
// [RQ3] The override enable bit selects manual tie-off control, else automatic control.
// [RQ4] Boosted buffer bypass bit closes its bypass switch while that buffer is off.
// [RQ5] Unity buffer bypass bit closes its bypass switch while that buffer is off.
// [RQ6] The left speaker tie-off bit forces its switch closed on 1, open on 0.
// [RQ7] The right speaker tie-off bit forces its switch closed on 1, open on 0.
// [RQ8] The first auxiliary tie-off bit forces its switch closed on 1, open on 0.
// [RQ9] The second auxiliary tie-off bit forces its switch closed on 1, open on 0.
// [RQ10] The left headphone tie-off bit forces its switch closed on 1, open on 0.
// [RQ11] The right headphone tie-off bit forces its switch closed on 1, open on 0.
// [RQ12] Software loads the three unlock words with fixed values, any order, for 4-wire mode.
// [RQ13] Override and unlock registers are 9 bits wide and clear to zero at reset.
// [RQ14] Writes to the mute status flags are ignored.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "otsu_consts.vh"
module otsu_regs #(
  parameter GAIN_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  output wire awready,
  input wire [11:0] awaddr,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output wire bvalid,
  input wire bready,
  output wire [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [11:0] araddr,
  output wire rvalid,
  input wire rready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  input wire dac_automute_active,
  input wire [GAIN_W-1:0] left_dac_gain,
  input wire [GAIN_W-1:0] right_dac_gain,
  input wire [7:0] auto_switch,
  input wire boosted_buffer_disabled,
  input wire unboosted_buffer_disabled,
  output wire boosted_bypass_close,
  output wire unboosted_bypass_close,
  output wire left_speaker_output_tie_close,
  output wire right_speaker_output_tie_close,
  output wire first_auxiliary_output_tie_close,
  output wire second_auxiliary_output_tie_close,
  output wire left_headphone_output_tie_close,
  output wire right_headphone_output_tie_close,
  output wire four_wire_enable,
  output wire irq
);
  wire wr_en;
  wire [7:0] wr_idx;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  reg wr_ok;
  wire [7:0] rd_idx;
  reg [31:0] rd_data;
  reg rd_ok;
  wire [7:0] switch_d;

  reg [8:0] override_q;
  reg [8:0] unlock_a_q;
  reg [8:0] unlock_b_q;
  reg [8:0] unlock_c_q;
  reg analog_automute_flag_q;
  reg left_digital_mute_flag_q;
  reg right_digital_mute_flag_q;
  reg four_wire_q;
  reg [3:0] irq_status_q;
  reg [3:0] irq_status_d;
  reg [3:0] irq_enable_q;
  reg [7:0] switch_q;
  reg irq_q;

  wire left_mute_d;
  wire right_mute_d;
  wire four_wire_d;
  wire [3:0] events;
  wire [3:0] irq_clear;

  // merge a write into a 9-bit register honouring byte lanes
  function [8:0] lane_merge;
    input [8:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      lane_merge[7:0] = strb[0] ? data[7:0] : old[7:0];
      lane_merge[8] = strb[1] ? data[8] : old[8];
    end
  endfunction

  // index decode shared by read and write paths
  function is_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `OTSU_IDX_MUTE_STATUS: is_mapped = 1'b1;
        `OTSU_IDX_OVERRIDE: is_mapped = 1'b1;
        `OTSU_IDX_UNLOCK_A: is_mapped = 1'b1;
        `OTSU_IDX_UNLOCK_B: is_mapped = 1'b1;
        `OTSU_IDX_UNLOCK_C: is_mapped = 1'b1;
        `OTSU_IDX_IRQ_STATUS: is_mapped = 1'b1;
        `OTSU_IDX_IRQ_CLEAR: is_mapped = 1'b1;
        `OTSU_IDX_IRQ_ENABLE: is_mapped = 1'b1;
        `OTSU_IDX_SERIAL_STATUS: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // unmapped words answer SLVERR from the front end, mapped ones OKAY
  otsu_axil_slave i_otsu_axil_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  always @* begin
    wr_ok = is_mapped(wr_idx);
    rd_ok = is_mapped(rd_idx);
  end

  // register writes; mute status index is accepted but stores nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      override_q <= `OTSU_RST_REG9; // [RQ13]
      unlock_a_q <= `OTSU_RST_REG9; // [RQ13]
      unlock_b_q <= `OTSU_RST_REG9; // [RQ13]
      unlock_c_q <= `OTSU_RST_REG9; // [RQ13]
      irq_enable_q <= `OTSU_RST_IRQ;
    end else if (wr_en) begin
      case (wr_idx)
        `OTSU_IDX_OVERRIDE: begin
          override_q <= lane_merge(override_q, wr_data, wr_strb);
        end
        `OTSU_IDX_UNLOCK_A: begin
          unlock_a_q <= lane_merge(unlock_a_q, wr_data, wr_strb);
        end
        `OTSU_IDX_UNLOCK_B: begin
          unlock_b_q <= lane_merge(unlock_b_q, wr_data, wr_strb);
        end
        `OTSU_IDX_UNLOCK_C: begin
          unlock_c_q <= lane_merge(unlock_c_q, wr_data, wr_strb);
        end
        `OTSU_IDX_IRQ_ENABLE: begin
          if (wr_strb[0]) begin
            irq_enable_q <= wr_data[3:0];
          end
        end
        // read-only words: answered with OKAY, nothing stored
        `OTSU_IDX_MUTE_STATUS: begin
          override_q <= override_q; // [RQ14]
        end
        `OTSU_IDX_IRQ_STATUS: begin
          override_q <= override_q;
        end
        `OTSU_IDX_SERIAL_STATUS: begin
          override_q <= override_q;
        end
        default: begin
          override_q <= override_q; // [RQ14]
        end
      endcase
    end
  end

  // mute flags follow the mute logic only, never the bus
  assign left_mute_d = (left_dac_gain == {GAIN_W{1'b0}}); // [RQ2]
  assign right_mute_d = (right_dac_gain == {GAIN_W{1'b0}}); // [RQ2]

  always @(posedge aclk) begin
    if (!aresetn) begin
      analog_automute_flag_q <= 1'b0;
      left_digital_mute_flag_q <= 1'b0;
      right_digital_mute_flag_q <= 1'b0;
    end else begin
      analog_automute_flag_q <= dac_automute_active; // [RQ1]
      left_digital_mute_flag_q <= left_mute_d; // [RQ2] [RQ14]
      right_digital_mute_flag_q <= right_mute_d; // [RQ2] [RQ14]
    end
  end

  // 4-wire mode stays on only while all three words hold their values
  assign four_wire_d = (unlock_a_q == `OTSU_UNLOCK_A_VAL) &&
                       (unlock_b_q == `OTSU_UNLOCK_B_VAL) &&
                       (unlock_c_q == `OTSU_UNLOCK_C_VAL); // [RQ12]

  always @(posedge aclk) begin
    if (!aresetn) begin
      four_wire_q <= 1'b0;
    end else begin
      four_wire_q <= four_wire_d; // [RQ12]
    end
  end

  assign four_wire_enable = four_wire_q;

  // rising edges of the flags are the interrupt events
  // flags reset low, so an input already active at release raises an event
  assign events[`OTSU_EV_ANALOG] = dac_automute_active && !analog_automute_flag_q;
  assign events[`OTSU_EV_LEFT] = left_mute_d && !left_digital_mute_flag_q;
  assign events[`OTSU_EV_RIGHT] = right_mute_d && !right_digital_mute_flag_q;
  assign events[`OTSU_EV_UNLOCK] = four_wire_d && !four_wire_q;
  assign irq_clear = (wr_en && wr_idx == `OTSU_IDX_IRQ_CLEAR && wr_strb[0]) ?
                     wr_data[3:0] : 4'h0;

  always @* begin
    // a set in the clearing cycle wins
    irq_status_d = (irq_status_q & ~irq_clear) | events;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= `OTSU_RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= irq_status_d;
      // an enable write reaches irq one edge later; keeps irq a flop output
      irq_q <= |(irq_status_d & irq_enable_q);
    end
  end

  assign irq = irq_q;

  otsu_tieoff_mux i_otsu_tieoff_mux (
    .override(override_q),
    .auto_switch(auto_switch),
    .boosted_buffer_disabled(boosted_buffer_disabled),
    .unboosted_buffer_disabled(unboosted_buffer_disabled),
    .switch_close(switch_d)
  );

  // switch drives come from flops so they cannot glitch
  always @(posedge aclk) begin
    if (!aresetn) begin
      switch_q <= 8'h00;
    end else begin
      switch_q <= switch_d; // [RQ3]
    end
  end

  assign boosted_bypass_close = switch_q[`OTSU_OVR_BUF_BOOST];
  assign unboosted_bypass_close = switch_q[`OTSU_OVR_BUF_UNITY];
  assign left_speaker_output_tie_close = switch_q[`OTSU_OVR_LSPK];
  assign right_speaker_output_tie_close = switch_q[`OTSU_OVR_RSPK];
  assign first_auxiliary_output_tie_close = switch_q[`OTSU_OVR_AUX1];
  assign second_auxiliary_output_tie_close = switch_q[`OTSU_OVR_AUX2];
  assign left_headphone_output_tie_close = switch_q[`OTSU_OVR_LHP];
  assign right_headphone_output_tie_close = switch_q[`OTSU_OVR_RHP];

  // read mux; clear register reads as zero
  always @* begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      `OTSU_IDX_MUTE_STATUS: begin
        rd_data[`OTSU_MUTE_ANALOG] = analog_automute_flag_q; // [RQ1]
        rd_data[`OTSU_MUTE_LEFT] = left_digital_mute_flag_q; // [RQ2]
        rd_data[`OTSU_MUTE_RIGHT] = right_digital_mute_flag_q; // [RQ2]
      end
      `OTSU_IDX_OVERRIDE: rd_data[8:0] = override_q;
      `OTSU_IDX_UNLOCK_A: rd_data[8:0] = unlock_a_q;
      `OTSU_IDX_UNLOCK_B: rd_data[8:0] = unlock_b_q;
      `OTSU_IDX_UNLOCK_C: rd_data[8:0] = unlock_c_q;
      `OTSU_IDX_IRQ_STATUS: rd_data[3:0] = irq_status_q;
      `OTSU_IDX_IRQ_ENABLE: rd_data[3:0] = irq_enable_q;
      `OTSU_IDX_SERIAL_STATUS: rd_data[0] = four_wire_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end
endmodule

// ---- design/otsu_tieoff_mux.v ----
// Purpose: choose manual or automatic control for each output tie-off switch
// Assumes: switch vectors ordered as the override bits 7..0
// Notes: purely combinational, the caller registers the result
`timescale 1ns/1ps
`include "otsu_consts.vh"
module otsu_tieoff_mux (
  input wire [8:0] override,
  input wire [7:0] auto_switch,
  input wire boosted_buffer_disabled,
  input wire unboosted_buffer_disabled,
  output reg [7:0] switch_close
);
  always @* begin
    switch_close = auto_switch;
    if (override[`OTSU_OVR_ENABLE]) begin // [RQ3]
      // bypass only forced while its buffer is off, else automatic
      if (override[`OTSU_OVR_BUF_BOOST] && boosted_buffer_disabled) begin
        switch_close[`OTSU_OVR_BUF_BOOST] = 1'b1; // [RQ4]
      end
      if (override[`OTSU_OVR_BUF_UNITY] && unboosted_buffer_disabled) begin
        switch_close[`OTSU_OVR_BUF_UNITY] = 1'b1; // [RQ5]
      end
      switch_close[`OTSU_OVR_LSPK] = override[`OTSU_OVR_LSPK]; // [RQ6]
      switch_close[`OTSU_OVR_RSPK] = override[`OTSU_OVR_RSPK]; // [RQ7]
      switch_close[`OTSU_OVR_AUX1] = override[`OTSU_OVR_AUX1]; // [RQ8]
      switch_close[`OTSU_OVR_AUX2] = override[`OTSU_OVR_AUX2]; // [RQ9]
      switch_close[`OTSU_OVR_LHP] = override[`OTSU_OVR_LHP]; // [RQ10]
      switch_close[`OTSU_OVR_RHP] = override[`OTSU_OVR_RHP]; // [RQ11]
    end
  end
endmodule

// ---- sim/otsu_regs_monitor.sv ----
// Purpose: concurrent checks on tie-off switch outputs and unlock flag
// Assumes: override word changes only through completed bus writes
// Notes: a shadow of the override word is rebuilt from bus traffic
`timescale 1ns/1ps
`include "otsu_consts.vh"
module otsu_regs_monitor (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire [11:0] awaddr,
  input wire wvalid,
  input wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire bvalid,
  input wire [1:0] bresp,
  input wire [7:0] auto_switch,
  input wire boosted_buffer_disabled,
  input wire unboosted_buffer_disabled,
  input wire boosted_bypass_close,
  input wire unboosted_bypass_close,
  input wire left_speaker_output_tie_close,
  input wire right_speaker_output_tie_close,
  input wire first_auxiliary_output_tie_close,
  input wire second_auxiliary_output_tie_close,
  input wire left_headphone_output_tie_close,
  input wire right_headphone_output_tie_close,
  input wire four_wire_enable
);
  reg [11:0] aw_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg [8:0] ovr_q;
  reg bv_q;
  reg vq;
  reg [7:0] eq;
  wire [7:0] ex;
  wire [7:0] sw;
  assign sw = {boosted_bypass_close, unboosted_bypass_close,
    left_speaker_output_tie_close, right_speaker_output_tie_close,
    first_auxiliary_output_tie_close, second_auxiliary_output_tie_close,
    left_headphone_output_tie_close, right_headphone_output_tie_close};
  assign ex[5:0] = ovr_q[8] ? ovr_q[5:0] : auto_switch[5:0];
  // a set bypass bit only forces closing while its buffer is off
  assign ex[7] = auto_switch[7] | (ovr_q[8] & ovr_q[7] & boosted_buffer_disabled);
  assign ex[6] = auto_switch[6] | (ovr_q[8] & ovr_q[6] & unboosted_buffer_disabled);
  // checks skip the cycles around a write, when shadow and register differ
  always @(posedge aclk) begin
    if (!aresetn) begin
      ovr_q <= 9'h000;
      bv_q <= 1'b0;
      vq <= 1'b0;
      eq <= 8'h00;
    end else begin
      if (awvalid && awready)
        aw_q <= awaddr;
      if (wvalid && wready) begin
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (bvalid && !bv_q && bresp == `OTSU_RESP_OKAY &&
          aw_q[11:2] == {2'b00, `OTSU_IDX_OVERRIDE}) begin
        if (ws_q[0])
          ovr_q[7:0] <= wd_q[7:0];
        if (ws_q[1])
          ovr_q[8] <= wd_q[8];
      end
      bv_q <= bvalid;
      vq <= !bvalid && !bv_q;
      eq <= ex;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_auto_follow: assert property (vq && !ovr_q[8] |-> sw == $past(auto_switch))
    else $error("switches do not follow automatic control");
  a_boost_bypass: assert property (vq |-> sw[7] == eq[7])
    else $error("boosted bypass switch wrong");
  a_unity_bypass: assert property (vq |-> sw[6] == eq[6])
    else $error("unity bypass switch wrong");
  a_lspk_tie: assert property (vq |-> sw[5] == eq[5])
    else $error("left speaker tie-off wrong");
  a_rspk_tie: assert property (vq |-> sw[4] == eq[4])
    else $error("right speaker tie-off wrong");
  a_aux_one_tie: assert property (vq |-> sw[3] == eq[3])
    else $error("first aux tie-off wrong");
  a_aux_two_tie: assert property (vq |-> sw[2] == eq[2])
    else $error("second aux tie-off wrong");
  a_lhp_tie: assert property (vq |-> sw[1] == eq[1])
    else $error("left headphone tie-off wrong");
  a_rhp_tie: assert property (vq |-> sw[0] == eq[0])
    else $error("right headphone tie-off wrong");
  a_unlock_late: assert property ($rose(four_wire_enable) |-> $past(bvalid))
    else $error("four-wire mode rose without a write");
  a_reset_clear: assert property (disable iff (1'b0)
    !aresetn |=> sw == 8'h00 && !four_wire_enable)
    else $error("outputs not cleared by reset");
endmodule
bind otsu_regs otsu_regs_monitor i_otsu_regs_monitor (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
  .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bresp(bresp),
  .auto_switch(auto_switch), .boosted_buffer_disabled(boosted_buffer_disabled),
  .unboosted_buffer_disabled(unboosted_buffer_disabled),
  .boosted_bypass_close(boosted_bypass_close),
  .unboosted_bypass_close(unboosted_bypass_close),
  .left_speaker_output_tie_close(left_speaker_output_tie_close),
  .right_speaker_output_tie_close(right_speaker_output_tie_close),
  .first_auxiliary_output_tie_close(first_auxiliary_output_tie_close),
  .second_auxiliary_output_tie_close(second_auxiliary_output_tie_close),
  .left_headphone_output_tie_close(left_headphone_output_tie_close),
  .right_headphone_output_tie_close(right_headphone_output_tie_close),
  .four_wire_enable(four_wire_enable));

// ---- sim/otsu_regs_tb.sv ----
// Purpose: self-checking bench for tie-off override, mute and unlock registers
// Assumes: one write and one read in flight, answers checked from queues
// Notes: strobes vary so the upper override bit is kept or replaced
`timescale 1ns/1ps
`include "otsu_consts.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module otsu_regs_tb;
  reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg am = 0, bd = 0, ud = 0;
  reg [11:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, d;
  reg [3:0] wstrb = 4'hf;
  reg [7:0] lg = 8'h10, rg = 8'h10, asw = 8'h00;
  reg [8:0] v = 9'h000;
  wire awready, wready, bvalid, arready, rvalid, fwe, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] sw;
  integer n_fail = 0, checks_done = 0, seed = 32'h2c5ecbc7, i;
  reg [33:0] rq[$];
  reg [1:0] bq[$];
  reg [1:0] br;
  reg [33:0] rx;
  localparam [1:0] ok_r = `OTSU_RESP_OKAY, er_r = `OTSU_RESP_SLVERR;
  otsu_regs #(.GAIN_W(8)) i_otsu_regs (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .dac_automute_active(am), .left_dac_gain(lg), .right_dac_gain(rg),
    .auto_switch(asw), .boosted_buffer_disabled(bd), .unboosted_buffer_disabled(ud),
    .boosted_bypass_close(sw[7]), .unboosted_bypass_close(sw[6]),
    .left_speaker_output_tie_close(sw[5]), .right_speaker_output_tie_close(sw[4]),
    .first_auxiliary_output_tie_close(sw[3]), .second_auxiliary_output_tie_close(sw[2]),
    .left_headphone_output_tie_close(sw[1]), .right_headphone_output_tie_close(sw[0]),
    .four_wire_enable(fwe), .irq(irq));
  initial begin
    forever #50 aclk = ~aclk;
  end
  function [11:0] ba(input [7:0] x);
    ba = {2'b00, x, 2'b00};
  endfunction
  function [7:0] xsw(input [8:0] o);
    begin
      xsw = o[8] ? {asw[7:6], o[5:0]} : asw;
      xsw[7] = asw[7] | (o[8] & o[7] & bd);
      xsw[6] = asw[6] | (o[8] & o[6] & ud);
    end
  endfunction
  task wr(input [11:0] a, input [31:0] dt, input [1:0] r);
    reg ad, wd;
    begin
      ad = 0;
      wd = 0;
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= dt;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ad && wd)) begin
        @(posedge aclk);
        ad = ad | awready;
        wd = wd | wready;
        awvalid <= !ad;
        wvalid <= !wd;
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] dt, input [1:0] r);
    begin
      rq.push_back({r, dt});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 0;
    end
  endtask
  // pop once per answer; the macro reads its expected value twice
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      br = bq.pop_front();
      `CHK(bresp, br)
    end
    if (rvalid && rready) begin
      rx = rq.pop_front();
      `CHK({rresp, rdata}, rx)
    end
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(ba(`OTSU_IDX_OVERRIDE), 0, ok_r);
    rd(ba(`OTSU_IDX_UNLOCK_A), 0, ok_r);
    rd(ba(`OTSU_IDX_UNLOCK_B), 0, ok_r);
    rd(ba(`OTSU_IDX_UNLOCK_C), 0, ok_r);
    rd(ba(`OTSU_IDX_MUTE_STATUS), 0, ok_r);
    `CHK(fwe, 1'b0)
    $display("test reset done");
    d = $random(seed);
    am <= 1;
    lg <= 0;
    rg <= d[7:0] | 8'h01;
    rd(ba(`OTSU_IDX_MUTE_STATUS), 32'h6, ok_r);
    wr(ba(`OTSU_IDX_MUTE_STATUS), 32'h0, ok_r);
    rd(ba(`OTSU_IDX_MUTE_STATUS), 32'h6, ok_r);
    am <= 0;
    rg <= 0;
    rd(ba(`OTSU_IDX_MUTE_STATUS), 32'h3, ok_r);
    $display("test mute done");
    `CHK(irq, 1'b0)
    rd(ba(`OTSU_IDX_IRQ_STATUS), 32'h7, ok_r);
    wr(ba(`OTSU_IDX_IRQ_ENABLE), 32'h2, ok_r);
    @(negedge aclk);
    `CHK(irq, 1'b1)
    wr(ba(`OTSU_IDX_IRQ_CLEAR), 32'hf, ok_r);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    rd(ba(`OTSU_IDX_IRQ_STATUS), 0, ok_r);
    wr(ba(`OTSU_IDX_IRQ_ENABLE), 32'h1, ok_r);
    am <= 1;
    repeat (4) @(posedge aclk);
    `CHK(irq, 1'b1)
    $display("test interrupt done");
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      asw <= d[31:24];
      bd <= d[23];
      ud <= d[22];
      wstrb <= {2'b11, d[21], 1'b1};
      v = {d[21] ? d[8] : v[8], d[7:0]};
      wr(ba(`OTSU_IDX_OVERRIDE), d, ok_r);
      @(negedge aclk);
      `CHK(sw, xsw(v))
      rd(ba(`OTSU_IDX_OVERRIDE), {23'h0, v}, ok_r);
    end
    $display("test override done");
    // unlock words carry bit 8, so both low byte lanes must be written
    wstrb <= 4'hf;
    wr(ba(`OTSU_IDX_UNLOCK_C), {23'h0, `OTSU_UNLOCK_C_VAL}, ok_r);
    wr(ba(`OTSU_IDX_UNLOCK_A), {23'h0, `OTSU_UNLOCK_A_VAL}, ok_r);
    @(negedge aclk);
    `CHK(fwe, 1'b0)
    wr(ba(`OTSU_IDX_UNLOCK_B), {23'h0, `OTSU_UNLOCK_B_VAL}, ok_r);
    @(negedge aclk);
    `CHK(fwe, 1'b1)
    rd(ba(`OTSU_IDX_IRQ_STATUS), 32'h9, ok_r);
    rd(ba(`OTSU_IDX_SERIAL_STATUS), 32'h1, ok_r);
    rd(ba(`OTSU_IDX_UNLOCK_B), {23'h0, `OTSU_UNLOCK_B_VAL}, ok_r);
    wr(ba(`OTSU_IDX_UNLOCK_B), 32'h03a, ok_r);
    @(negedge aclk);
    `CHK(fwe, 1'b0)
    $display("test unlock done");
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(ba(`OTSU_IDX_OVERRIDE), 0, ok_r);
    rd(ba(`OTSU_IDX_UNLOCK_A), 0, ok_r);
    `CHK(fwe, 1'b0)
    $display("test mid-run reset done");
    wr(12'h400, 32'h1ff, er_r);
    rd(12'h400, 0, er_r);
    rd(12'h010, 0, er_r);
    $display("test unmapped done");
    stop_test;
  end
endmodule
